// ===== accel_mode_status_irq_regs.sv
// Behaviour
// - Standby stops clocks and axis sampling.
// - Wake runs clocks and samples three axes.
// - Status low bits mirror operating state.
// - Resolution indicator always reads zero.
// - Watchdog event sets flag, resets slave.
// - Status read clears watchdog flag.
// - Busy bit follows nonvolatile memory activity.
// - No FIFO enables in interrupt enable.
// - Tilt needs its enable and tilt/flip.
// - Flip needs its enable and tilt/flip.
// - Any-motion needs its enable and feature.
// - Shake needs enable, shake and any-motion.
// - Tilt-angle needs enable, feature and any-motion.
// - Without auto clear, host write clears.
// - Auto clear drops flag when condition ends.
// - Sample-done flag after each sample, enabled.
// - Mode register writable in every state.
// - Low-stall enable arms low watchdog.
// - High-stall enable arms high watchdog.
`timescale 1ns/1ns
module accel_mode_status_irq_regs (
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Register port from the serial protocol engine.
    input wire accel_regs_pkg::reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Serial clock monitoring.
    input wire logic scl_level,
    input wire logic xfer_active,
    output logic slave_reset,
    // Motion block and core inputs.
    input wire logic [7:0] motion_ctrl,
    input wire logic [4:0] motion_event,
    input wire logic sample_acquired,
    input wire logic nvm_active,
    // Core control outputs.
    output logic core_clk_run,
    output logic sample_enable,
    output logic low_stall_watchdog_enable,
    output logic high_stall_watchdog_enable,
    output logic [5:0] irq_pending
);
    import accel_regs_pkg::*;

    // Stored state of the mode and interrupt enable registers.
    logic [1:0] op_state;
    logic [7:0] ien;
    logic bus_watchdog_flag;
    logic stall_pulse;
    logic any_motion_irq_enable;
    logic auto_clear_enable;
    logic sample_done_irq_enable;
    logic [NUM_SOURCES-1:0] gated_cond;
    logic [NUM_SOURCES-1:0] pending;
    logic [7:0] status_value;
    logic [7:0] next_rdata;
    logic host_irq_clear;
    logic status_read;

    // Decoded accesses.
    assign status_read = reg_req.rd && reg_req.addr == ADDR_DEVICE_STATUS;
    assign host_irq_clear = reg_req.wr && reg_req.addr == ADDR_IRQ_STATUS;

    // The mode register takes writes in standby and wake alike.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            op_state <= RESET_OPERATING_MODE_CTRL[MODE_STATE_LSB +: 2];
            low_stall_watchdog_enable <= RESET_OPERATING_MODE_CTRL[MODE_LOW_STALL_BIT];
            high_stall_watchdog_enable <= RESET_OPERATING_MODE_CTRL[MODE_HIGH_STALL_BIT];
        end else if (clk_en && reg_req.wr && reg_req.addr == ADDR_OPERATING_MODE_CTRL) begin
            // Bit 2 is ignored here; software is expected to keep it zero.
            low_stall_watchdog_enable <= reg_req.wdata[MODE_LOW_STALL_BIT];
            high_stall_watchdog_enable <= reg_req.wdata[MODE_HIGH_STALL_BIT];
            // Reserved codes would leave the core in an undefined state.
            if (reg_req.wdata[MODE_STATE_LSB +: 2] == STATE_STANDBY ||
                reg_req.wdata[MODE_STATE_LSB +: 2] == STATE_WAKE) begin
                op_state <= reg_req.wdata[MODE_STATE_LSB +: 2];
            end
        end
    end

    // Clocks and sampling follow the operating state directly.
    assign core_clk_run = (op_state == STATE_WAKE);
    assign sample_enable = (op_state == STATE_WAKE);

    // Interrupt enable register holds no FIFO enables.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ien <= RESET_INTERRUPT_ENABLE_CTRL;
        end else if (clk_en && reg_req.wr && reg_req.addr == ADDR_INTERRUPT_ENABLE_CTRL) begin
            ien <= reg_req.wdata & IEN_WRITE_MASK;
        end
    end

    assign any_motion_irq_enable = ien[IEN_ANYM_BIT];
    assign auto_clear_enable = ien[IEN_AUTO_CLR_BIT];
    assign sample_done_irq_enable = ien[IEN_SAMPLE_DONE_BIT];

    // Each source is reported only with its enable and its feature bits.
    always_comb begin
        gated_cond = '0;
        gated_cond[IEN_TILT_BIT] = motion_event[IEN_TILT_BIT] && ien[IEN_TILT_BIT] &&
            motion_ctrl[MC_TILT_FLIP_BIT];
        gated_cond[IEN_FLIP_BIT] = motion_event[IEN_FLIP_BIT] && ien[IEN_FLIP_BIT] &&
            motion_ctrl[MC_TILT_FLIP_BIT];
        gated_cond[IEN_ANYM_BIT] = motion_event[IEN_ANYM_BIT] && any_motion_irq_enable &&
            motion_ctrl[MC_ANYM_BIT];
        gated_cond[IEN_SHAKE_BIT] = motion_event[IEN_SHAKE_BIT] && ien[IEN_SHAKE_BIT] &&
            motion_ctrl[MC_SHAKE_BIT] && motion_ctrl[MC_ANYM_BIT];
        gated_cond[IEN_TILT35_BIT] = motion_event[IEN_TILT35_BIT] && ien[IEN_TILT35_BIT] &&
            motion_ctrl[MC_TILT35_BIT] && motion_ctrl[MC_ANYM_BIT];
        // Samples only arrive in wake, so this cannot fire in standby.
        gated_cond[SRC_SAMPLE_DONE] = sample_acquired && sample_done_irq_enable &&
            sample_enable;
    end

    // Pending flags with host or automatic clearing.
    irq_status_latch u_irq (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .cond(gated_cond),
        .auto_clear(auto_clear_enable),
        .host_clear(host_irq_clear),
        .pending(pending)
    );
    assign irq_pending = pending;

    // Serial clock stall detector.
    bus_stall_watchdog u_wdt (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .scl_level(scl_level),
        .xfer_active(xfer_active),
        .low_enable(low_stall_watchdog_enable),
        .high_enable(high_stall_watchdog_enable),
        .stall_pulse(stall_pulse)
    );

    // A new stall in the read cycle wins over the read's clear.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_watchdog_flag <= 1'b0;
        end else if (clk_en) begin
            if (stall_pulse) begin
                bus_watchdog_flag <= 1'b1;
            end else if (status_read) begin
                bus_watchdog_flag <= 1'b0;
            end
        end
    end

    // The protocol engine returns to idle on the same pulse.
    assign slave_reset = stall_pulse;

    // Status word; reserved bits and the resolution bit read zero.
    always_comb begin
        status_value = READ_ZERO;
        status_value[MODE_STATE_LSB +: 2] = op_state;
        status_value[STAT_RES_BIT] = 1'b0;
        status_value[STAT_WDT_BIT] = bus_watchdog_flag;
        status_value[STAT_NVM_BIT] = nvm_active;
    end

    // Read data mux; unmapped addresses read zero.
    always_comb begin
        case (reg_req.addr)
            ADDR_DEVICE_STATUS: next_rdata = status_value;
            ADDR_INTERRUPT_ENABLE_CTRL: next_rdata = ien;
            ADDR_OPERATING_MODE_CTRL: next_rdata = {2'h0, high_stall_watchdog_enable,
                low_stall_watchdog_enable, 2'h0, op_state};
            default: next_rdata = READ_ZERO;
        endcase
    end

    // Read data is registered, one cycle after the read strobe.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= READ_ZERO;
        end else if (clk_en && reg_req.rd) begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

// ===== accel_regs_pkg.sv
package accel_regs_pkg;

    // Register addresses on the internal register port.
    localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h05;
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE_CTRL = 8'h06;
    localparam logic [7:0] ADDR_OPERATING_MODE_CTRL = 8'h07;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;

    // Reset values.
    localparam logic [7:0] RESET_INTERRUPT_ENABLE_CTRL = 8'h00;
    localparam logic [7:0] RESET_OPERATING_MODE_CTRL = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Operating state codes.
    localparam logic [1:0] STATE_STANDBY = 2'h0;
    localparam logic [1:0] STATE_WAKE = 2'h1;

    // Field positions in the mode register.
    localparam int MODE_STATE_LSB = 0;
    localparam int MODE_LOW_STALL_BIT = 4;
    localparam int MODE_HIGH_STALL_BIT = 5;
    localparam logic [7:0] MODE_WRITE_MASK = 8'h33;

    // Field positions in the interrupt enable register.
    localparam int IEN_TILT_BIT = 0;
    localparam int IEN_FLIP_BIT = 1;
    localparam int IEN_ANYM_BIT = 2;
    localparam int IEN_SHAKE_BIT = 3;
    localparam int IEN_TILT35_BIT = 4;
    localparam int IEN_AUTO_CLR_BIT = 6;
    localparam int IEN_SAMPLE_DONE_BIT = 7;
    localparam logic [7:0] IEN_WRITE_MASK = 8'hDF;

    // Field positions in the motion control register.
    localparam int MC_TILT_FLIP_BIT = 0;
    localparam int MC_ANYM_BIT = 2;
    localparam int MC_SHAKE_BIT = 3;
    localparam int MC_TILT35_BIT = 4;

    // Field positions in the status register.
    localparam int STAT_RES_BIT = 2;
    localparam int STAT_WDT_BIT = 4;
    localparam int STAT_NVM_BIT = 7;

    // Motion interrupt sources, one bit each, plus sample done.
    localparam int NUM_SOURCES = 6;
    localparam int SRC_SAMPLE_DONE = 5;

    // Watchdog stall timeout.
    localparam int WDT_TIMEOUT_US = 10;
    localparam int CLK_MHZ = 125;
    localparam int WDT_TIMEOUT_CYCLES = WDT_TIMEOUT_US * CLK_MHZ;
    localparam int WDT_CNT_W = 11;

    // Register access request from the serial protocol engine.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// ===== bus_stall_watchdog.sv
`timescale 1ns/1ns
module bus_stall_watchdog
    import accel_regs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Serial clock observation.
    input wire logic scl_level,
    input wire logic xfer_active,
    input wire logic low_enable,
    input wire logic high_enable,
    // Stall event, one cycle.
    output logic stall_pulse
);
    // Cycles the serial clock has stood at its current level.
    logic [WDT_CNT_W-1:0] hold_cnt;
    logic last_level;
    logic armed;

    // The timer is armed only for the level whose watchdog is enabled.
    assign armed = xfer_active && ((scl_level && high_enable) || (!scl_level && low_enable));

    // Counting restarts on any edge, so only a true stall can expire it.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt <= '0;
            last_level <= 1'b1;
            stall_pulse <= 1'b0;
        end else if (clk_en) begin
            last_level <= scl_level;
            stall_pulse <= 1'b0;
            if (!armed || scl_level != last_level) begin
                hold_cnt <= '0;
            end else if (hold_cnt == WDT_CNT_W'(WDT_TIMEOUT_CYCLES - 1)) begin
                // Fires once, then restarts so a lasting stall repeats.
                hold_cnt <= '0;
                stall_pulse <= 1'b1;
            end else begin
                hold_cnt <= hold_cnt + 1'b1;
            end
        end
    end
endmodule

// ===== irq_status_latch.sv
`timescale 1ns/1ns
module irq_status_latch
    import accel_regs_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Gated conditions and control.
    input wire logic [NUM_SOURCES-1:0] cond,
    input wire logic auto_clear,
    input wire logic host_clear,
    // Pending flags.
    output logic [NUM_SOURCES-1:0] pending
);
    // One sticky flag per source.
    genvar i;
    generate
        for (i = 0; i < NUM_SOURCES; i++) begin : g_src
            // A condition in the clear cycle wins over the clear.
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    pending[i] <= 1'b0;
                end else if (clk_en) begin
                    if (cond[i]) begin
                        pending[i] <= 1'b1;
                    end else if (auto_clear) begin
                        pending[i] <= 1'b0;
                    end else if (host_clear) begin
                        pending[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate
endmodule

// ===== accel_regs_assertions.sv
`timescale 1ns/1ns
module accel_regs_assertions (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Register port.
    input wire accel_regs_pkg::reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // Serial clock watch.
    input wire logic scl_level,
    input wire logic xfer_active,
    input wire logic slave_reset,
    // Core side.
    input wire logic [7:0] motion_ctrl,
    input wire logic [4:0] motion_event,
    input wire logic sample_acquired,
    input wire logic nvm_active,
    input wire logic core_clk_run,
    input wire logic sample_enable,
    input wire logic low_stall_watchdog_enable,
    input wire logic high_stall_watchdog_enable,
    input wire logic [5:0] irq_pending
);
    import accel_regs_pkg::*;
    logic [1:0] st; // Shadow of the last valid state written.
    logic [7:0] ien; // Shadow of the interrupt enables.
    logic [1:0] wd; // Shadow of the two stall watchdog enables, high then low.
    logic [5:0] g; // Gated interrupt conditions.
    logic last_scl; // Serial clock one cycle ago.
    int hold; // Cycles the armed line has stood still.
    wire logic wr14 = reg_req.wr && reg_req.addr == ADDR_IRQ_STATUS;
    wire logic arm = xfer_active && (scl_level ? high_stall_watchdog_enable
                                               : low_stall_watchdog_enable);
    // Reserved codes are skipped so the shadow keeps the last good state.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= STATE_STANDBY;
            ien <= 8'h00;
            wd <= 2'h0;
        end else if (reg_req.wr) begin
            if (reg_req.addr == ADDR_OPERATING_MODE_CTRL && !reg_req.wdata[1])
                st <= reg_req.wdata[1:0];
            if (reg_req.addr == ADDR_OPERATING_MODE_CTRL)
                wd <= reg_req.wdata[5:4];
            if (reg_req.addr == ADDR_INTERRUPT_ENABLE_CTRL)
                ien <= reg_req.wdata;
        end
    end
    // Stall length counter, one cycle behind the design at worst.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold <= 0;
            last_scl <= 1'b1;
        end else begin
            last_scl <= scl_level;
            hold <= (arm && scl_level == last_scl) ? hold + 1 : 0;
        end
    end
    // Shake and tilt-angle also need the any-motion feature.
    always_comb begin
        g[0] = motion_event[0] && ien[0] && motion_ctrl[0];
        g[1] = motion_event[1] && ien[1] && motion_ctrl[0];
        g[2] = motion_event[2] && ien[2] && motion_ctrl[2];
        g[3] = motion_event[3] && ien[3] && motion_ctrl[3] && motion_ctrl[2];
        g[4] = motion_event[4] && ien[4] && motion_ctrl[4] && motion_ctrl[2];
        g[5] = sample_acquired && ien[7] && st == STATE_WAKE;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_state_run: assert property (core_clk_run == (st == STATE_WAKE))
        else $error("core clock run disagrees with state");
    a_sample_run: assert property (sample_enable == core_clk_run)
        else $error("sampling disagrees with clock run");
    a_wdt_enables: assert property ({high_stall_watchdog_enable, low_stall_watchdog_enable} == wd)
        else $error("stall watchdog enables disagree with mode writes");
    a_status_read: assert property (reg_req.rd && reg_req.addr == ADDR_DEVICE_STATUS |=>
        reg_rdata[2:0] == {1'b0, $past(st)} && reg_rdata[7] == $past(nvm_active))
        else $error("status read content wrong");
    a_rise_gated: assert property ((irq_pending & ~$past(irq_pending) & ~$past(g)) == 6'h00)
        else $error("pending set without gated cause");
    a_set_next: assert property ((irq_pending & $past(g)) == $past(g))
        else $error("gated cause not latched");
    a_hold_pending: assert property ($past(!ien[6] && !wr14) |->
        ($past(irq_pending) & ~irq_pending) == 6'h00)
        else $error("pending dropped without host clear");
    a_auto_clear: assert property ($past(ien[6] && !wr14) |->
        (irq_pending & $past(irq_pending & ~g)) == 6'h00)
        else $error("auto clear missed");
    a_host_clear: assert property ($past(wr14) |-> (irq_pending & ~$past(g)) == 6'h00)
        else $error("host clear missed");
    a_stall_early: assert property (slave_reset |-> hold >= WDT_TIMEOUT_CYCLES - 8)
        else $error("stall declared too early");
    a_stall_late: assert property (hold == WDT_TIMEOUT_CYCLES - 8 |-> ##[0:16] slave_reset)
        else $error("stall not declared");
    c_stall: cover property (slave_reset);
    c_clear: cover property ($past(wr14) && $past(irq_pending) != 6'h00);
    c_busy: cover property (reg_req.rd && reg_req.addr == ADDR_DEVICE_STATUS && nvm_active);
endmodule

// ===== serial_host_model.sv
`timescale 1ns/1ns
module serial_host_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Scenario control.
    input wire logic run,
    input wire logic stall,
    input wire logic stall_lvl,
    // Serial line as the block sees it.
    output logic scl_level,
    output logic xfer_active
);
    logic [1:0] ph; // Half-period phase.
    // The line idles high on its pull-up; a stall freezes it at stall_lvl.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph <= 2'h0;
            scl_level <= 1'b1;
        end else if (!run) begin
            ph <= 2'h0;
            scl_level <= 1'b1;
        end else if (!(stall && scl_level == stall_lvl)) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3) begin
                scl_level <= !scl_level;
            end
        end
    end
    assign xfer_active = run;
endmodule

// ===== accel_mode_status_irq_regs_test.sv
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module accel_mode_status_irq_regs_test;
    import accel_regs_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    reg_req_t reg_req = '0;
    logic [7:0] reg_rdata, motion_ctrl = 8'h00, e_rd;
    logic [4:0] motion_event = 5'h00;
    logic sample_acquired = 1'b0, nvm_active = 1'b0, run = 1'b0, stall = 1'b0, lvl = 1'b0;
    logic scl_level, xfer_active, slave_reset, rd_seen = 1'b0;
    logic [5:0] irq_pending;
    logic [7:0] expq[$]; // Expected read data, oldest first.
    int fails = 0, total_checks = 0, cyc = 0;
    always #4 clk = ~clk;
    accel_mode_status_irq_regs accel_mode_status_irq_regs_i (.clk(clk), .rst_b(rst_b),
        .clk_en(1'b1), .reg_req(reg_req), .reg_rdata(reg_rdata), .scl_level(scl_level),
        .xfer_active(xfer_active), .slave_reset(slave_reset), .motion_ctrl(motion_ctrl),
        .motion_event(motion_event), .sample_acquired(sample_acquired),
        .nvm_active(nvm_active), .core_clk_run(), .sample_enable(),
        .low_stall_watchdog_enable(), .high_stall_watchdog_enable(),
        .irq_pending(irq_pending));
    serial_host_model serial_host_model_i (.clk(clk), .rst_b(rst_b), .run(run),
        .stall(stall), .stall_lvl(lvl), .scl_level(scl_level), .xfer_active(xfer_active));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One access; a read notes its expected data for the watcher.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        if (!w) expq.push_back(d);
        @(posedge clk);
        reg_req <= '0;
    endtask
    // Read data is valid the cycle after the read is taken.
    always @(posedge clk) begin
        if (rd_seen) begin
            e_rd = expq.pop_front();
            `CHECK("reg_rdata", e_rd, reg_rdata)
        end
        rd_seen <= reg_req.rd;
    end
    // A hang is cut short well beyond the expected run length.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        int k, n;
        logic [7:0] ie, mc;
        logic [4:0] ev;
        k = $urandom(32'hDC70);
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        acc(0, ADDR_DEVICE_STATUS, 8'h00);
        acc(0, ADDR_INTERRUPT_ENABLE_CTRL, 8'h00);
        acc(0, ADDR_OPERATING_MODE_CTRL, 8'h00);
        acc(0, 8'h3C, 8'h00);
        acc(1, ADDR_OPERATING_MODE_CTRL, 8'h01);
        acc(0, ADDR_DEVICE_STATUS, 8'h01);
        acc(1, ADDR_OPERATING_MODE_CTRL, 8'h32);
        acc(0, ADDR_OPERATING_MODE_CTRL, 8'h31);
        nvm_active <= 1'b1;
        acc(0, ADDR_DEVICE_STATUS, 8'h81);
        nvm_active <= 1'b0;
        acc(1, ADDR_OPERATING_MODE_CTRL, 8'h00);
        acc(0, ADDR_DEVICE_STATUS, 8'h00);
        $display("mode and status test done");
        repeat (24) begin
            ie = 8'($urandom) & 8'h1F;
            mc = 8'($urandom);
            ev = 5'($urandom);
            acc(1, ADDR_INTERRUPT_ENABLE_CTRL, ie);
            motion_ctrl <= mc;
            @(posedge clk);
            motion_event <= ev;
            @(posedge clk);
            motion_event <= 5'h00;
            repeat (2) @(negedge clk);
            `CHECK("irq_pending", {1'b0, ev & ie[4:0] & {mc[4] & mc[2], mc[3] & mc[2], mc[2], mc[0], mc[0]}}, irq_pending)
            acc(1, ADDR_IRQ_STATUS, 8'h00);
            @(negedge clk);
            `CHECK("irq_pending", 6'h00, irq_pending)
        end
        acc(1, ADDR_INTERRUPT_ENABLE_CTRL, 8'h44);
        motion_ctrl <= 8'h04;
        @(posedge clk);
        motion_event <= 5'h04;
        @(posedge clk);
        motion_event <= 5'h00;
        @(negedge clk);
        `CHECK("irq_pending", 6'h04, irq_pending)
        @(negedge clk);
        `CHECK("irq_pending", 6'h00, irq_pending)
        acc(1, ADDR_OPERATING_MODE_CTRL, 8'h01);
        acc(1, ADDR_INTERRUPT_ENABLE_CTRL, 8'h80);
        sample_acquired <= 1'b1;
        @(posedge clk);
        sample_acquired <= 1'b0;
        @(negedge clk);
        `CHECK("irq_pending", 6'h20, irq_pending)
        acc(1, ADDR_IRQ_STATUS, 8'h00);
        $display("interrupt test done");
        for (k = 0; k < 2; k++) begin
            acc(1, ADDR_OPERATING_MODE_CTRL, (k == 0) ? 8'h10 : 8'h20);
            run <= 1'b1;
            stall <= 1'b1;
            lvl <= k[0];
            n = 0;
            while (slave_reset !== 1'b1 && n < 2000) begin
                @(negedge clk);
                n++;
            end
            `CHECK("slave_reset", 1'b1, slave_reset)
            @(posedge clk);
            run <= 1'b0;
            stall <= 1'b0;
            repeat (3) @(posedge clk);
            acc(0, ADDR_DEVICE_STATUS, 8'h10);
            acc(0, ADDR_DEVICE_STATUS, 8'h00);
        end
        repeat (3) @(posedge clk);
        $display("watchdog test done");
        stop_test();
    end
endmodule
bind accel_mode_status_irq_regs accel_regs_assertions accel_regs_assertions_i (
    .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .scl_level(scl_level), .xfer_active(xfer_active), .slave_reset(slave_reset),
    .motion_ctrl(motion_ctrl), .motion_event(motion_event),
    .sample_acquired(sample_acquired), .nvm_active(nvm_active),
    .core_clk_run(core_clk_run), .sample_enable(sample_enable),
    .low_stall_watchdog_enable(low_stall_watchdog_enable),
    .high_stall_watchdog_enable(high_stall_watchdog_enable), .irq_pending(irq_pending));
